// ---- hw/bfp_top.sv ----
// Breaker failure decision logic with APB settings and interrupt
//
// Our own choices: register access over APB and the placing of the registers.
module bfp_top #(
  parameter int unsigned CLK_PER_MS = bfp_pkg::CYC_PER_MS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic general_start_in_i,
  input wire logic start_phase1_in_i,
  input wire logic start_phase2_in_i,
  input wire logic start_phase3_in_i,
  input wire logic breaker_closed_in_i,
  input wire logic breaker_closed_phase1_in_i,
  input wire logic breaker_closed_phase2_in_i,
  input wire logic breaker_closed_phase3_in_i,
  input wire logic inhibit_in_i,
  input wire logic [2:0] phase_current_threshold_i,
  input wire logic residual_current_threshold_i,
  output logic backup_trip_o,
  output logic [2:0] retrip_o,
  output logic irq_o
);

  // Settings
  logic [3:0] ctrl;
  logic [15:0] backup_ms;
  logic [9:0] retrip_ms;
  logic [15:0] pulse_ms;
  logic [3:0] status;
  logic [3:0] mask;
  bfp_pkg::bfp_mode_e mode;
  logic retrip_en;
  logic single_pole;

  // Time base
  logic [16:0] div_cnt;
  logic tick;

  // Per phase signals
  logic [2:0] start_ph;
  logic [2:0] closed_ph;
  logic [2:0] current_ph;
  logic [2:0] fault_ph;
  logic [2:0] running_ph;
  logic [2:0] backup_fire_ph;
  logic [2:0] retrip_fire_ph;
  logic enable;
  logic backup_fire;
  logic [2:0] retrip_fire;
  logic [3:0] events;

  // Bus decode
  logic apb_access;
  logic apb_write;
  logic apb_read;
  logic addr_ok;
  logic status_rd;
  logic [31:0] next_rdata;
  logic [15:0] retrip_clamped;

  // Out of range writes saturate at the nearest limit
  function automatic logic [15:0] clamp16(input logic [31:0] v,
                                          input logic [15:0] lo,
                                          input logic [15:0] hi);
    logic [15:0] r;
    r = v[15:0];
    if (v > {16'h0000, hi}) begin
      r = hi;
    end else if (v < {16'h0000, lo}) begin
      r = lo;
    end
    return r;
  endfunction : clamp16

  // Control fields
  assign mode = bfp_pkg::bfp_mode_e'(ctrl[bfp_pkg::CTRL_MODE_LSB +: 2]);
  assign retrip_en = ctrl[bfp_pkg::CTRL_RETRIP_BIT];
  assign single_pole = ctrl[bfp_pkg::CTRL_SP_BIT];

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      div_cnt <= 17'h00000;
      tick <= 1'b0;
    end else if (div_cnt >= 17'(CLK_PER_MS - 1)) begin
      div_cnt <= 17'h00000;
      tick <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 17'h00001;
      tick <= 1'b0;
    end
  end

  assign start_ph = {3{general_start_in_i}} |
                    ({start_phase3_in_i, start_phase2_in_i,
                      start_phase1_in_i} & {3{single_pole}});

  assign closed_ph = single_pole ?
                     {breaker_closed_phase3_in_i, breaker_closed_phase2_in_i,
                      breaker_closed_phase1_in_i} :
                     {3{breaker_closed_in_i}};

  assign current_ph = phase_current_threshold_i |
                      {3{residual_current_threshold_i}};

  always_comb begin
    case (mode)
      bfp_pkg::MODE_CURRENT: fault_ph = current_ph;
      bfp_pkg::MODE_CONTACT: fault_ph = closed_ph;
      bfp_pkg::MODE_BOTH: fault_ph = current_ph | closed_ph;
      default: fault_ph = 3'b000;
    endcase
  end

  assign enable = (mode != bfp_pkg::MODE_OFF) && !inhibit_in_i;

  // One timer pair and one retrip stretcher per phase
  for (genvar p = 0; p < 3; p++) begin : g_phase
    bfp_phase_timer u_timer (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .enable_i(enable),
      .start_i(start_ph[p]),
      .fault_i(fault_ph[p]),
      .backup_ms_i(backup_ms),
      .retrip_ms_i(retrip_ms),
      .running_o(running_ph[p]),
      .backup_fire_o(backup_fire_ph[p]),
      .retrip_fire_o(retrip_fire_ph[p])
    );

    bfp_pulse u_retrip (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .tick_i(tick),
      .clear_i(!enable),
      .trig_i(retrip_fire[p]),
      .dur_ms_i(pulse_ms),
      .pulse_o(retrip_o[p])
    );
  end

  // Any phase running off gives the common backup trip
  assign backup_fire = |backup_fire_ph;
  assign retrip_fire = retrip_fire_ph & {3{retrip_en && single_pole}};

  bfp_pulse u_backup (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .clear_i(!enable),
    .trig_i(backup_fire),
    .dur_ms_i(pulse_ms),
    .pulse_o(backup_trip_o)
  );

  // Status layout: bit 0 backup, bits 3:1 retrip per phase
  assign events = {retrip_fire, backup_fire};

  // APB slave, zero wait states
  assign pready_o = 1'b1;
  assign apb_access = psel_i && penable_i;
  assign apb_write = apb_access && pwrite_i;
  assign apb_read = apb_access && !pwrite_i;
  // Unmapped offsets answer with an error
  assign pslverr_o = apb_access && !addr_ok;
  // A status read clears what it reported
  assign status_rd = apb_read && (paddr_i == bfp_pkg::STATUS_OFS);

  // Mapped register offsets
  always_comb begin
    case (paddr_i)
      bfp_pkg::CTRL_OFS,
      bfp_pkg::BACKUP_OFS,
      bfp_pkg::RETRIP_OFS,
      bfp_pkg::PULSE_OFS,
      bfp_pkg::STATUS_OFS,
      bfp_pkg::MASK_OFS,
      bfp_pkg::STATE_OFS: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end

  // Read mux; unused upper bits read as zero
  always_comb begin
    next_rdata = 32'h00000000;
    case (paddr_i)
      bfp_pkg::CTRL_OFS: next_rdata[3:0] = ctrl;
      bfp_pkg::BACKUP_OFS: next_rdata[15:0] = backup_ms;
      bfp_pkg::RETRIP_OFS: next_rdata[9:0] = retrip_ms;
      bfp_pkg::PULSE_OFS: next_rdata[15:0] = pulse_ms;
      bfp_pkg::STATUS_OFS: next_rdata[3:0] = status;
      bfp_pkg::MASK_OFS: next_rdata[3:0] = mask;
      bfp_pkg::STATE_OFS: begin
        next_rdata[3:0] = {retrip_o, backup_trip_o};
        next_rdata[6:4] = running_ph;
      end
      default: next_rdata = 32'h00000000;
    endcase
  end

  // Read data registered at setup, stable through the access phase
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      prdata_o <= 32'h00000000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      prdata_o <= next_rdata;
    end
  end

  // Control register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl <= bfp_pkg::CTRL_RST;
    end else if (apb_write && paddr_i == bfp_pkg::CTRL_OFS) begin
      ctrl <= pwdata_i[3:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      backup_ms <= bfp_pkg::BACKUP_RST;
    end else if (apb_write && paddr_i == bfp_pkg::BACKUP_OFS) begin
      backup_ms <= clamp16(pwdata_i, bfp_pkg::BACKUP_MIN,
                           bfp_pkg::BACKUP_MAX);
    end
  end

  // Retrip limit widened to the clamp width
  assign retrip_clamped = clamp16(pwdata_i, 16'h0000,
                                  {6'h00, bfp_pkg::RETRIP_MAX});

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      retrip_ms <= bfp_pkg::RETRIP_RST;
    end else if (apb_write && paddr_i == bfp_pkg::RETRIP_OFS) begin
      retrip_ms <= retrip_clamped[bfp_pkg::RTR_W-1:0];
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_ms <= bfp_pkg::PULSE_RST;
    end else if (apb_write && paddr_i == bfp_pkg::PULSE_OFS) begin
      pulse_ms <= clamp16(pwdata_i, 16'h0000, bfp_pkg::PULSE_MAX);
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      mask <= bfp_pkg::MASK_RST;
    end else if (apb_write && paddr_i == bfp_pkg::MASK_OFS) begin
      mask <= pwdata_i[3:0];
    end
  end

  // Sticky events; a new event wins over the read clear
  // Only bits already shown in the read data are cleared, so an event
  // landing during the setup cycle is kept for the next read
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      status <= 4'h0;
    end else if (status_rd) begin
      status <= (status & ~prdata_o[3:0]) | events;
    end else begin
      status <= status | events;
    end
  end

  // Level interrupt, one cycle behind status
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

endmodule : bfp_top

// ---- hw/bfp_pkg.sv ----
// Constants, register map and state types of the breaker failure block
// What this block does
// - Start edge launches per-phase backup, retrip timers
// - Supervise only while timers run, per mode
// - Current mode uses current flags only
// - Contact mode uses breaker closed inputs only
// - Combined mode resets only when both faultless
// - Mode off gives no outputs
// - Backup trip at expiry if fault persists
// - Trip pulses last the pulse duration, up to 1 ms short
// - Retrip per phase after both timers expire, in single pole mode only
// - Inhibit input blocks all trip outputs
// - Backup delay 100 to 60000 ms, 1000
// - Retrip delay 0 to 1000 ms, 100
// - Pulse duration 0 to 60000 ms, 100
package bfp_pkg;

  // Time base
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned MS_NS = 1000000;
  localparam int unsigned CYC_PER_MS = MS_NS / CLK_PERIOD_NS;

  // Setting widths
  localparam int unsigned DLY_W = 16;
  localparam int unsigned RTR_W = 10;

  // Setting ranges and defaults, in milliseconds
  localparam logic [15:0] BACKUP_MIN = 16'd100;
  localparam logic [15:0] BACKUP_MAX = 16'd60000;
  localparam logic [15:0] BACKUP_RST = 16'd1000;
  localparam logic [9:0] RETRIP_MAX = 10'd1000;
  localparam logic [9:0] RETRIP_RST = 10'd100;
  localparam logic [15:0] PULSE_MAX = 16'd60000;
  localparam logic [15:0] PULSE_RST = 16'd100;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] BACKUP_OFS = 8'h04;
  localparam logic [7:0] RETRIP_OFS = 8'h08;
  localparam logic [7:0] PULSE_OFS = 8'h0c;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  localparam logic [7:0] MASK_OFS = 8'h14;
  localparam logic [7:0] STATE_OFS = 8'h18;

  // Control field positions
  localparam int unsigned CTRL_MODE_LSB = 0;
  localparam int unsigned CTRL_RETRIP_BIT = 2;
  localparam int unsigned CTRL_SP_BIT = 3;
  localparam logic [3:0] CTRL_RST = 4'h0;

  // Status and mask layout: bit 0 backup, bits 3:1 retrip per phase
  localparam int unsigned EVT_W = 4;
  localparam logic [3:0] MASK_RST = 4'h0;

  typedef enum logic [1:0] {
    MODE_OFF = 2'h0,
    MODE_CURRENT = 2'h1,
    MODE_CONTACT = 2'h2,
    MODE_BOTH = 2'h3
  } bfp_mode_e;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN = 2'b01,
    ST_DONE = 2'b11
  } bfp_state_e;

endpackage : bfp_pkg

// ---- hw/bfp_phase_timer.sv ----
// Backup and retrip timer pair for one phase
module bfp_phase_timer (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic enable_i,
  input wire logic start_i,
  input wire logic fault_i,
  input wire logic [15:0] backup_ms_i,
  input wire logic [9:0] retrip_ms_i,
  output logic running_o,
  output logic backup_fire_o,
  output logic retrip_fire_o
);

  bfp_pkg::bfp_state_e state;
  logic start_q;
  logic [15:0] ms_cnt;
  logic backup_done;
  logic retrip_done;
  logic backup_hit;
  logic retrip_hit;

  assign backup_hit = (ms_cnt >= backup_ms_i);
  assign retrip_hit = (ms_cnt >= {6'h00, retrip_ms_i});
  assign running_o = (state == bfp_pkg::ST_RUN);

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      start_q <= 1'b0;
    end else begin
      start_q <= start_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state <= bfp_pkg::ST_IDLE;
      ms_cnt <= 16'h0000;
      backup_done <= 1'b0;
      retrip_done <= 1'b0;
      backup_fire_o <= 1'b0;
      retrip_fire_o <= 1'b0;
    end else begin
      backup_fire_o <= 1'b0;
      retrip_fire_o <= 1'b0;
      case (state)
        bfp_pkg::ST_IDLE: begin
          if (enable_i && start_i && !start_q) begin
            state <= bfp_pkg::ST_RUN;
            ms_cnt <= 16'h0000;
            backup_done <= 1'b0;
            retrip_done <= 1'b0;
          end
        end
        bfp_pkg::ST_RUN: begin
          if (!enable_i || !start_i || !fault_i) begin
            state <= bfp_pkg::ST_IDLE;
          end else begin
            if (tick_i && ms_cnt != 16'hffff) begin
              ms_cnt <= ms_cnt + 16'h0001;
            end
            if (backup_hit && !backup_done) begin
              backup_done <= 1'b1;
              backup_fire_o <= 1'b1;
            end
            if (backup_hit && retrip_hit && !retrip_done) begin
              retrip_done <= 1'b1;
              retrip_fire_o <= 1'b1;
            end
            if (backup_done && retrip_done) begin
              state <= bfp_pkg::ST_DONE;
            end
          end
        end
        bfp_pkg::ST_DONE: begin
          if (!enable_i || !start_i) begin
            state <= bfp_pkg::ST_IDLE;
          end
        end
        default: begin
          state <= bfp_pkg::ST_IDLE;
        end
      endcase
    end
  end

endmodule : bfp_phase_timer

// ---- hw/bfp_pulse.sv ----
// Trip pulse stretcher with a length in milliseconds, up to 1 ms short of the set duration
module bfp_pulse (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic tick_i,
  input wire logic clear_i,
  input wire logic trig_i,
  input wire logic [15:0] dur_ms_i,
  output logic pulse_o
);

  logic [15:0] remain;

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      pulse_o <= 1'b0;
      remain <= 16'h0000;
    end else if (clear_i) begin
      pulse_o <= 1'b0;
      remain <= 16'h0000;
    end else if (trig_i) begin
      pulse_o <= 1'b1;
      remain <= dur_ms_i;
    end else if (pulse_o) begin
      if (remain == 16'h0000) begin
        pulse_o <= 1'b0;
      end else if (tick_i) begin
        remain <= remain - 16'h0001;
      end
    end
  end

endmodule : bfp_pulse

// ---- sim/bfp_partner.sv ----
// Far-side model: upstream protection starts, current flags and breaker
module bfp_partner (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fault_i,
  input wire logic sp_i,
  input wire logic cur_off_i,
  input wire logic brk_off_i,
  output logic gen_start_o,
  output logic [2:0] start_o,
  output logic [2:0] cur_o,
  output logic res_o,
  output logic brk_o,
  output logic [2:0] brk_ph_o
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      gen_start_o <= 1'b0;
      start_o <= 3'h0;
      cur_o <= 3'h0;
      res_o <= 1'b0;
      brk_o <= 1'b1;
      brk_ph_o <= 3'h7;
    end else begin
      gen_start_o <= fault_i & ~sp_i;
      start_o <= {2'b00, fault_i & sp_i};
      cur_o <= {3{fault_i & ~cur_off_i}};
      res_o <= fault_i & ~cur_off_i;
      // Breaker reads closed unless told it opened
      brk_o <= ~brk_off_i;
      brk_ph_o <= {3{~brk_off_i}};
    end
  end
endmodule : bfp_partner

// ---- sim/bfp_chk.sv ----
// Port checker for the breaker failure block
module bfp_chk #(
  parameter int unsigned CLK_PER_MS = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pslverr_o,
  input wire logic general_start_in_i,
  input wire logic start_phase1_in_i,
  input wire logic inhibit_in_i,
  input wire logic backup_trip_o,
  input wire logic [2:0] retrip_o,
  input wire logic irq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] ctrl_q;
  logic [15:0] pulse_q;
  logic [3:0] mask_q;
  logic [31:0] scnt;
  logic [31:0] wcnt;
  logic wr;
  assign wr = psel_i & penable_i & pwrite_i;
  // Shadow of the settings written over the bus
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      ctrl_q <= bfp_pkg::CTRL_RST;
      pulse_q <= bfp_pkg::PULSE_RST;
      mask_q <= bfp_pkg::MASK_RST;
    end else if (wr) begin
      if (paddr_i == bfp_pkg::CTRL_OFS) ctrl_q <= pwdata_i[3:0];
      if (paddr_i == bfp_pkg::PULSE_OFS) begin
        pulse_q <= (pwdata_i > {16'h0000, bfp_pkg::PULSE_MAX}) ?
                   bfp_pkg::PULSE_MAX : pwdata_i[15:0];
      end
      if (paddr_i == bfp_pkg::MASK_OFS) mask_q <= pwdata_i[3:0];
    end
  end
  // Cycles a start is held, cycles the trip is high
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      scnt <= 32'h0;
      wcnt <= 32'h0;
    end else begin
      scnt <= (general_start_in_i | start_phase1_in_i) ? scnt + 32'h1 : 32'h0;
      wcnt <= backup_trip_o ? wcnt + 32'h1 : 32'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  sequence s_access;
    psel_i && penable_i;
  endsequence
  sequence s_off_held;
    (ctrl_q[1:0] == 2'h0) [*3];
  endsequence
  a_bad_addr_err: assert property (
    s_access ##0 (paddr_i > 8'h18) |-> pslverr_o)
    else $error("unmapped access without error");
  a_good_addr_ok: assert property (
    s_access ##0 (paddr_i <= 8'h18 && paddr_i[1:0] == 2'h0) |-> !pslverr_o)
    else $error("mapped access flagged as error");
  a_err_read_zero: assert property (
    s_access ##0 (!pwrite_i && pslverr_o) |-> prdata_o == 32'h0)
    else $error("unmapped read data not zero");
  a_inhibit_quiet: assert property (
    inhibit_in_i |=> !backup_trip_o && retrip_o == 3'h0)
    else $error("trip output while inhibited");
  a_off_quiet: assert property (
    s_off_held |-> !backup_trip_o && retrip_o == 3'h0)
    else $error("trip output with mode off");
  a_trip_delay: assert property (
    $rose(backup_trip_o) |-> scnt >= 99 * CLK_PER_MS)
    else $error("backup trip before its delay");
  a_pulse_len: assert property (
    $fell(backup_trip_o) && !$past(inhibit_in_i) && ctrl_q[1:0] != 2'h0
    |-> wcnt + CLK_PER_MS >= pulse_q * CLK_PER_MS)
    else $error("trip pulse too short");
  a_irq_raise: assert property (
    $rose(backup_trip_o) && mask_q[0] |=> irq_o)
    else $error("interrupt missing after backup trip");
  a_retrip_gate: assert property (
    $rose(retrip_o != 3'h0)
    |-> ctrl_q[3:2] == 2'h3 && scnt >= 99 * CLK_PER_MS)
    else $error("retrip without enable or before backup delay");
endmodule : bfp_chk

bind bfp_top bfp_chk #(.CLK_PER_MS(CLK_PER_MS)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
  .prdata_o(prdata_o), .pslverr_o(pslverr_o),
  .general_start_in_i(general_start_in_i),
  .start_phase1_in_i(start_phase1_in_i), .inhibit_in_i(inhibit_in_i),
  .backup_trip_o(backup_trip_o), .retrip_o(retrip_o), .irq_o(irq_o)
);

// ---- sim/test_breaker_failure_protection.sv ----
// Testbench for the breaker failure block
module test_breaker_failure_protection;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic pready, pslverr, e, trip, irq, gen, res, brk;
  logic [2:0] retrip, st, cur, brkp;
  logic fault = 1'b0, sp = 1'b0, co = 1'b0, bo = 1'b0, inh = 1'b0;
  logic [7:0] t;
  int error_cnt = 0;
  int compares = 0;
  // Rows: mode, current off, breaker open, single pole, inhibit, gap, trip
  logic [7:0] tbl [11] = '{
    8'h49, 8'h68, 8'ha9, 8'h98,
    8'he9, 8'hd9, 8'hf8, 8'h08,
    8'h4c, 8'h4a, 8'h41};
  `define CHK(n, x, v) begin compares++; if ((v) !== (x)) begin \
    error_cnt++; $display("wrong value %s expected %h seen %h", n, x, v); \
    end end
  always #4 clk_i = ~clk_i;
  bfp_top #(.CLK_PER_MS(10)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .general_start_in_i(gen), .start_phase1_in_i(st[0]),
    .start_phase2_in_i(st[1]), .start_phase3_in_i(st[2]),
    .breaker_closed_in_i(brk), .breaker_closed_phase1_in_i(brkp[0]),
    .breaker_closed_phase2_in_i(brkp[1]),
    .breaker_closed_phase3_in_i(brkp[2]), .inhibit_in_i(inh),
    .phase_current_threshold_i(cur), .residual_current_threshold_i(res),
    .backup_trip_o(trip), .retrip_o(retrip), .irq_o(irq));
  bfp_partner u_far (
    .clk_i(clk_i), .rst_i(rst_i), .fault_i(fault), .sp_i(sp),
    .cur_off_i(co), .brk_off_i(bo), .gen_start_o(gen), .start_o(st),
    .cur_o(cur), .res_o(res), .brk_o(brk), .brk_ph_o(brkp));
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_i);
    penable <= 1'b1;
    @(posedge clk_i);
    while (pready !== 1'b1 && n < 16) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 16) error_cnt++;
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task rdchk(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    `CHK("register", x, r)
  endtask : rdchk
  task summarize;
    $display("errors %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : summarize
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    summarize();
  end
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    rdchk(bfp_pkg::CTRL_OFS, 32'h0);
    rdchk(bfp_pkg::BACKUP_OFS, 32'd1000);
    rdchk(bfp_pkg::RETRIP_OFS, 32'd100);
    rdchk(bfp_pkg::PULSE_OFS, 32'd100);
    rdchk(bfp_pkg::STATUS_OFS, 32'h0);
    rdchk(bfp_pkg::MASK_OFS, 32'h0);
    apb(1'b0, 8'h1c, 32'h0);
    `CHK("error", 1'b1, e)
    `CHK("unmapped", 32'h0, r)
    apb(1'b1, bfp_pkg::BACKUP_OFS, 32'd5);
    rdchk(bfp_pkg::BACKUP_OFS, 32'd100);
    apb(1'b1, bfp_pkg::BACKUP_OFS, 32'd70000);
    rdchk(bfp_pkg::BACKUP_OFS, 32'd60000);
    apb(1'b1, bfp_pkg::BACKUP_OFS, 32'd100);
    apb(1'b1, bfp_pkg::RETRIP_OFS, 32'd2000);
    rdchk(bfp_pkg::RETRIP_OFS, 32'd1000);
    apb(1'b1, bfp_pkg::RETRIP_OFS, 32'd20);
    apb(1'b1, bfp_pkg::PULSE_OFS, 32'd60001);
    rdchk(bfp_pkg::PULSE_OFS, 32'd60000);
    apb(1'b1, bfp_pkg::PULSE_OFS, 32'd5);
    for (int i = 0; i < 11; i++) begin
      t = tbl[i];
      apb(1'b1, bfp_pkg::CTRL_OFS, {28'h0, t[3], 1'b1, t[7:6]});
      apb(1'b1, bfp_pkg::MASK_OFS, {31'h0, i[0]});
      co <= t[5];
      bo <= t[4];
      sp <= t[3];
      inh <= t[2];
      fault <= 1'b1;
      repeat (500) @(posedge clk_i);
      if (t[1]) begin
        fault <= 1'b0;
        @(posedge clk_i);
        fault <= 1'b1;
      end
      repeat (530) @(posedge clk_i);
      `CHK("backup", t[0], trip)
      `CHK("retrip", {2'b00, t[0] & t[3]}, retrip)
      `CHK("irq", t[0] & i[0], irq)
      rdchk(bfp_pkg::STATE_OFS,
            {25'h0, 2'b00, t[1], 2'b00, t[0] & t[3], t[0]});
      apb(1'b0, bfp_pkg::STATUS_OFS, 32'h0);
      `CHK("status", {30'h0, t[0] & t[3], t[0]}, r)
      fault <= 1'b0;
      repeat (2) @(posedge clk_i);
      `CHK("held", t[0], trip)
      `CHK("irq clear", 1'b0, irq)
      repeat (100) @(posedge clk_i);
      `CHK("ended", 1'b0, trip)
    end
    summarize();
  end
endmodule : test_breaker_failure_protection
